// ---- logic/sdbi_pkg.sv ----
// shared constants, types and crc helper of the sd bus link
package sdbi_pkg;
  // frame lengths and counts, in bus clocks or bits
  localparam logic [7:0] CMD_LEN = 8'h30; // command and short response bits
  localparam logic [7:0] LONG_LEN = 8'h88; // long response bits
  localparam logic [7:0] UNITS_1 = 8'h20; // data steps on one line
  localparam logic [7:0] UNITS_4 = 8'h08; // data steps on four lines
  localparam logic [7:0] DUMMY_CLKS = 8'h50; // idle clocks after reset, more than 74
  localparam logic [7:0] RESP_TMO = 8'h40; // bus clocks allowed before a start bit
  localparam logic [1:0] NCR = 2'h2; // bus clocks between command and response
  localparam logic [1:0] PWRUP_POLLS = 2'h2; // voltage polls until power-up done
  // link clock: host divider and the fastest rate the card side is rated for
  localparam int REF_MHZ = 100;
  localparam int LINK_MAX_MHZ = 50;
  localparam int LINK_PERIOD_NS = 160;
  localparam logic [7:0] HALF_CYC = 8'(LINK_PERIOD_NS * REF_MHZ / 2000);
  // command indexes
  localparam logic [5:0] IX_GO_IDLE = 6'h00;
  localparam logic [5:0] IX_ALL_ID = 6'h02;
  localparam logic [5:0] IX_REL_ADDR = 6'h03;
  localparam logic [5:0] IX_BUS_W = 6'h06;
  localparam logic [5:0] IX_SELECT = 6'h07;
  localparam logic [5:0] IX_SEND_SPEC = 6'h09;
  localparam logic [5:0] IX_SEND_ID = 6'h0a;
  localparam logic [5:0] IX_STATUS = 6'h0d;
  localparam logic [5:0] IX_READ = 6'h11;
  localparam logic [5:0] IX_WRITE = 6'h18;
  localparam logic [5:0] IX_OP_COND = 6'h29;
  localparam logic [5:0] IX_PULLUP = 6'h2a;
  localparam logic [5:0] IX_APP = 6'h37;
  localparam logic [5:0] IX_LONG = 6'h3f; // index field of long and ocr answers
  localparam logic [6:0] CRC_NONE = 7'h7f; // crc field of the ocr answer
  // card contents
  localparam int OCR_BUSY_BIT = 31;
  localparam logic [31:0] OCR_VOLT = 32'h00ff_8000; // 2.7 to 3.6 v window
  localparam logic [31:0] STAT_WORD = 32'h0000_0100; // card kind field in low 16 bits
  localparam int STAT_ST_LSB = 9; // card state field of the short status
  localparam logic [1:0] BUSW_4 = 2'h2;
  localparam logic [15:0] LFSR_SEED = 16'h5a3c;
  localparam logic [127:0] ID_VAL = 128'h0123_4567_89ab_cdef_0011_2233_4455_6677; // arbitrary
  localparam logic [127:0] SPEC_VAL = 128'h400e_0032_5b59_0000_1d8f_7f80_0a40_0001;
  // host register map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ARG = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_RESP0 = 8'h10;
  localparam logic [7:0] A_RESP1 = 8'h14;
  localparam logic [7:0] A_RESP2 = 8'h18;
  localparam logic [7:0] A_RESP3 = 8'h1c;
  localparam logic [7:0] A_DATA = 8'h20;
  localparam int CR_RK_LSB = 6;
  localparam int CR_DIR_LSB = 8;
  localparam logic [1:0] DIR_RD = 2'h1;
  localparam logic [1:0] DIR_WR = 2'h2;

  typedef enum logic [1:0] {RK_NONE = 2'h0, RK_R1 = 2'h1, RK_R2 = 2'h2, RK_R3 = 2'h3} sdbi_rk_t;
  typedef enum logic [4:0] {
    C_IDLE = 5'b00001, C_READY = 5'b00010, C_IDENT = 5'b00100,
    C_STBY = 5'b01000, C_TRAN = 5'b10000
  } sdbi_card_st_t;
  typedef enum logic [4:0] {
    H_INIT = 5'b00001, H_IDLE = 5'b00010, H_CMD = 5'b00100,
    H_RESP = 5'b01000, H_DATA = 5'b10000
  } sdbi_host_st_t;

  // crc7 over the first 40 bits of a frame, polynomial x^7 + x^3 + 1
  function automatic logic [6:0] sdbi_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ ({7{fb}} & 7'h09);
    end
    return c;
  endfunction
endpackage

// ---- logic/sdbi_if.sv ----
// link between host and card: clock, command line, four data lines
`timescale 1ns/1ps
interface sdbi_if;
  logic sdClk;
  logic hCmdO;
  logic hCmdOe;
  logic dCmdO;
  logic dCmdOe;
  logic [3:0] hDatO;
  logic [3:0] hDatOe;
  logic [3:0] dDatO;
  logic [3:0] dDatOe;
  logic dPullEn;
  logic cmdLine;
  logic [3:0] datLine;
  // wire levels; undriven lines float high on the pull-ups
  assign cmdLine = hCmdOe ? hCmdO : (dCmdOe ? dCmdO : 1'b1);
  assign datLine = (hDatOe & hDatO) | (~hDatOe & dDatOe & dDatO) | (~hDatOe & ~dDatOe);
  modport host (output sdClk, hCmdO, hCmdOe, hDatO, hDatOe, input cmdLine, datLine, dPullEn);
  modport dev (input sdClk, cmdLine, datLine, output dCmdO, dCmdOe, dDatO, dDatOe, dPullEn);
endinterface

// ---- logic/sdbi_card.sv ----
// card end of the sd bus link: command decoder, responses and data blocks
`timescale 1ns/1ps
module sdbi_card (
  input wire logic ref_clk, // system clock
  input wire logic srst, // synchronous reset, stands in for power-up
  sdbi_if.dev bus, // link pins
  output sdbi_pkg::sdbi_card_st_t cardState, // current card state
  output logic spiMode, // spi mode chosen at the last reset command
  output logic wideBus, // four data lines in use
  output logic [15:0] relAddr, // published relative card address
  output logic [31:0] storedWord // last block written by the host
);
  import sdbi_pkg::*;

  typedef struct packed {
    logic clkA, clkB, clkPrev, cmdA, cmdB;
    logic [3:0] datA, datB;
    sdbi_card_st_t st;
    logic spi, wide, app, pullEn, pwrOk;
    logic [1:0] polls;
    logic [15:0] relative_card_address, lfsr;
    logic [31:0] mem;
    logic rxOn;
    logic [7:0] rxCnt;
    logic [47:0] rxSr;
    logic [1:0] txWait;
    logic [7:0] txCnt;
    logic [135:0] txSr;
    logic dRd, dWr;
    logic [7:0] dIdx;
    logic [31:0] dSr;
    logic cmdO, cmdOe;
    logic [3:0] datO, datOe;
  } sdbi_card_s_t;

  sdbi_card_s_t r;
  sdbi_card_s_t n;
  logic rise, fall, got, sel;
  logic [7:0] units;
  logic [47:0] frm;
  logic [5:0] idx;
  logic [31:0] arg, word, stWord;
  logic [127:0] val;
  sdbi_rk_t kind;

  always_comb begin
    n = r;
    got = 1'b0;
    kind = RK_NONE;
    word = 32'h0000_0000;
    val = ID_VAL;
    // two flops on every pin; edges of the host clock found on the second
    n.clkA = bus.sdClk;
    n.clkB = r.clkA;
    n.clkPrev = r.clkB;
    n.cmdA = bus.cmdLine;
    n.cmdB = r.cmdA;
    n.datA = bus.datLine;
    n.datB = r.datA;
    // oversampling caps the usable link clock near half of ref_clk
    rise = r.clkB & ~r.clkPrev;
    fall = ~r.clkB & r.clkPrev;
    // free running lfsr, so each address request draws a new value
    n.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
    units = r.wide ? UNITS_4 : UNITS_1;
    frm = {r.rxSr[46:0], r.cmdB};
    idx = frm[45:40];
    arg = frm[39:8];
    sel = arg[31:16] == r.relative_card_address;
    stWord = 32'(r.st) << STAT_ST_LSB;
    // command receiver, sampled on rising link edges
    if (rise) begin
      if (r.rxOn) begin
        n.rxSr = frm;
        n.rxCnt = r.rxCnt + 8'h01;
        if (r.rxCnt == CMD_LEN - 8'h01) begin
          n.rxOn = 1'b0;
          got = frm[46] & frm[0];
        end
      end else if (!r.cmdB && !r.cmdOe && r.txCnt == 8'h00) begin
        n.rxOn = 1'b1;
        n.rxCnt = 8'h01;
        n.rxSr = 48'h0;
      end
    end
    // command decoder; anything unknown or out of state is dropped silently
    if (got) begin
      n.app = 1'b0;
      if (idx == IX_GO_IDLE) begin
        n.st = C_IDLE;
        n.spi = ~r.datB[3];
        n.wide = 1'b0;
        n.polls = 2'h0;
        n.pwrOk = 1'b0;
        n.dRd = 1'b0;
        n.dWr = 1'b0;
        n.dIdx = 8'h00;
      end else if (!r.spi) begin
        case (idx)
          IX_APP: begin
            n.app = 1'b1;
            kind = RK_R1;
            word = stWord;
          end
          IX_OP_COND: if (r.app && (r.st == C_IDLE || r.st == C_READY)) begin
            kind = RK_R3;
            word = OCR_VOLT;
            if (arg != 32'h0000_0000) begin
              n.polls = (r.polls == PWRUP_POLLS) ? r.polls : r.polls + 2'h1;
              if (r.polls + 2'h1 >= PWRUP_POLLS) begin
                n.pwrOk = 1'b1;
                n.st = C_READY;
                word[OCR_BUSY_BIT] = 1'b1;
              end
            end
          end
          IX_ALL_ID: if (r.st == C_READY) begin
            n.st = C_IDENT;
            kind = RK_R2;
          end
          IX_REL_ADDR: if (r.st == C_IDENT || r.st == C_STBY) begin
            n.relative_card_address = r.lfsr;
            n.st = C_STBY;
            kind = RK_R1;
            word = {r.lfsr, 16'h0000};
          end
          IX_SELECT: if (sel && (r.st == C_STBY || r.st == C_TRAN)) begin
            n.st = (r.st == C_STBY) ? C_TRAN : C_STBY;
            kind = RK_R1;
            word = stWord;
          end else if (r.st == C_TRAN) begin
            n.st = C_STBY;
          end
          IX_SEND_SPEC, IX_SEND_ID: if (sel && r.st == C_STBY) begin
            kind = RK_R2;
            val = (idx == IX_SEND_SPEC) ? SPEC_VAL : ID_VAL;
          end
          IX_BUS_W: if (r.app && r.st == C_TRAN) begin
            n.wide = arg[1:0] == BUSW_4;
            kind = RK_R1;
            word = stWord;
          end
          IX_PULLUP: if (r.app && r.st == C_TRAN) begin
            n.pullEn = arg[0];
            kind = RK_R1;
            word = stWord;
          end
          IX_STATUS, IX_READ: if (r.st == C_TRAN && (r.app || idx == IX_READ)) begin
            n.dSr = (idx == IX_READ) ? r.mem : STAT_WORD;
            n.dRd = 1'b1;
            n.dIdx = 8'h00;
            kind = RK_R1;
            word = stWord;
          end
          IX_WRITE: if (r.st == C_TRAN) begin
            n.dWr = 1'b1;
            n.dIdx = 8'h00;
            kind = RK_R1;
            word = stWord;
          end
          default: ;
        endcase
      end
    end
    // load the answer frame, sent after a short turnaround
    case (kind)
      RK_R1: n.txSr = {2'b00, idx, word, sdbi_crc7({2'b00, idx, word}), 1'b1, 88'h0};
      RK_R3: n.txSr = {2'b00, IX_LONG, word, CRC_NONE, 1'b1, 88'h0};
      RK_R2: n.txSr = {2'b00, IX_LONG, val[127:1], 1'b1};
      default: ;
    endcase
    if (kind != RK_NONE) begin
      n.txCnt = (kind == RK_R2) ? LONG_LEN : CMD_LEN;
      n.txWait = NCR;
    end
    // command line and read data change on falling link edges
    if (fall) begin
      if (r.txWait != 2'h0) begin
        n.txWait = r.txWait - 2'h1;
      end else if (r.txCnt != 8'h00) begin
        n.cmdOe = 1'b1;
        n.cmdO = r.txSr[135];
        n.txSr = {r.txSr[134:0], 1'b0};
        n.txCnt = r.txCnt - 8'h01;
      end else begin
        n.cmdOe = 1'b0;
        n.cmdO = 1'b1;
        if (r.dRd) begin
          n.datOe = r.wide ? 4'hf : 4'h1;
          n.dIdx = r.dIdx + 8'h01;
          if (r.dIdx == 8'h00) begin
            n.datO = 4'h0;
          end else if (r.dIdx <= units) begin
            n.datO = r.wide ? r.dSr[31:28] : {3'b111, r.dSr[31]};
            n.dSr = r.wide ? {r.dSr[27:0], 4'h0} : {r.dSr[30:0], 1'b0};
          end else if (r.dIdx == units + 8'h01) begin
            n.datO = 4'hf;
          end else begin
            n.datOe = 4'h0;
            n.dRd = 1'b0;
            n.dIdx = 8'h00;
          end
        end
      end
    end
    // write block: start on line zero, payload, then the stop bit is checked
    if (rise && r.dWr) begin
      if (r.dIdx == 8'h00) begin
        if (!r.datB[0]) n.dIdx = 8'h01;
      end else if (r.dIdx <= units) begin
        n.dSr = r.wide ? {r.dSr[27:0], r.datB} : {r.dSr[30:0], r.datB[0]};
        n.dIdx = r.dIdx + 8'h01;
      end else begin
        if (r.datB[0]) n.mem = r.dSr;
        n.dWr = 1'b0;
        n.dIdx = 8'h00;
      end
    end
  end

  // one register stage for all state; reset stands in for power-up
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r <= '0;
      r.st <= C_IDLE;
      r.pullEn <= 1'b1;
      r.lfsr <= LFSR_SEED;
      r.cmdO <= 1'b1;
      r.clkA <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign bus.dCmdO = r.cmdO;
  assign bus.dCmdOe = r.cmdOe;
  assign bus.dDatO = r.datO;
  assign bus.dDatOe = r.datOe;
  assign bus.dPullEn = r.pullEn;
  assign cardState = r.st;
  assign spiMode = r.spi;
  assign wideBus = r.wide;
  assign relAddr = r.relative_card_address;
  assign storedWord = r.mem;
endmodule

// ---- logic/sdbi_host.sv ----
// host end of the sd bus link: wishbone-controlled command and data engine
`timescale 1ns/1ps
module sdbi_host (
  input wire logic ref_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // write enable
  input wire logic [7:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte lanes
  input wire logic [31:0] wbDatW, // write data
  output logic [31:0] wbDatR, // read data
  output logic wbAck, // acknowledge
  output sdbi_pkg::sdbi_host_st_t hostState, // engine state
  sdbi_if.host bus // link pins
);
  import sdbi_pkg::*;

  typedef struct packed {
    sdbi_host_st_t st;
    logic [7:0] dv;
    logic sdClk, cmdA, cmdB;
    logic [3:0] datA, datB;
    logic wide, spiSel;
    logic [31:0] arg, cmdReg, txWord, rxWord;
    logic [127:0] rsp;
    logic tmoErr, stopErr, initDone;
    logic [7:0] cnt, tmo, dIdx;
    logic [47:0] sh;
    logic rxOn;
    logic [31:0] dSr;
    logic ack;
    logic [31:0] rdat;
    logic cmdO, cmdOe;
    logic [3:0] datO, datOe;
  } sdbi_host_s_t;

  sdbi_host_s_t r;
  sdbi_host_s_t n;
  logic tick, hRise, hFall, acc, wr;
  logic [31:0] m, merged, rd;
  logic [39:0] hdr;
  logic [7:0] units;
  sdbi_rk_t rk;
  logic [1:0] dir;

  always_comb begin
    n = r;
    m = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
    hdr = 40'h0;
    // pins pass two flops before anything looks at them
    n.cmdA = bus.cmdLine;
    n.cmdB = r.cmdA;
    n.datA = bus.datLine;
    n.datB = r.datA;
    // link clock divider; the host owns the clock and drives it out
    tick = r.dv == HALF_CYC - 8'h01;
    n.dv = tick ? 8'h00 : r.dv + 8'h01;
    hRise = tick & ~r.sdClk;
    hFall = tick & r.sdClk;
    if (tick) n.sdClk = ~r.sdClk;
    units = r.wide ? UNITS_4 : UNITS_1;
    rk = sdbi_rk_t'(r.cmdReg[CR_RK_LSB +: 2]);
    dir = r.cmdReg[CR_DIR_LSB +: 2];
    // wishbone slave: read data comes with the ack, a write lands at the edge that sees ack
    acc = wbCyc & wbStb & ~r.ack;
    wr = wbCyc & wbStb & wbWe & r.ack;
    merged = 32'h0;
    rd = 32'h0;
    n.ack = acc;
    if (acc || wr) begin
      case (wbAdr)
        A_CTRL: begin
          rd = {30'h0, r.spiSel, r.wide};
          if (wr && wbSel[0]) begin
            n.wide = wbDatW[0];
            n.spiSel = wbDatW[1];
          end
        end
        A_ARG: begin
          rd = r.arg;
          if (wr) n.arg = (r.arg & ~m) | (wbDatW & m);
        end
        A_CMD: begin
          rd = r.cmdReg;
          merged = (r.cmdReg & ~m) | (wbDatW & m);
          // a write while busy is ignored, the running command finishes first
          if (wr && r.st == H_IDLE) begin
            n.cmdReg = merged;
            hdr = {2'b01, merged[5:0], r.arg};
            n.sh = {hdr, sdbi_crc7(hdr), 1'b1};
            n.cnt = CMD_LEN;
            n.tmoErr = 1'b0;
            n.stopErr = 1'b0;
            n.st = H_CMD;
          end
        end
        A_STAT: rd = {28'h0, r.initDone, r.stopErr, r.tmoErr, r.st != H_IDLE};
        A_RESP0: rd = r.rsp[31:0];
        A_RESP1: rd = r.rsp[63:32];
        A_RESP2: rd = r.rsp[95:64];
        A_RESP3: rd = r.rsp[127:96];
        A_DATA: begin
          rd = r.rxWord;
          if (wr) n.txWord = (r.txWord & ~m) | (wbDatW & m);
        end
        default: rd = 32'h0;
      endcase
      if (acc) n.rdat = rd;
    end
    // data lines idle: only data3 may be pulled low for spi selection
    if (r.st != H_DATA) begin
      n.datO = 4'h0;
      n.datOe = {r.spiSel, 3'b000};
    end
    case (r.st)
      H_INIT: if (hRise) begin
        n.cnt = r.cnt + 8'h01;
        if (r.cnt == DUMMY_CLKS - 8'h01) begin
          n.st = H_IDLE;
          n.initDone = 1'b1;
          n.cnt = 8'h00;
        end
      end
      H_IDLE: ;
      H_CMD: if (hFall) begin
        if (r.cnt != 8'h00) begin
          n.cmdOe = 1'b1;
          n.cmdO = r.sh[47];
          n.sh = {r.sh[46:0], 1'b0};
          n.cnt = r.cnt - 8'h01;
        end else begin
          n.cmdOe = 1'b0;
          n.cmdO = 1'b1;
          n.tmo = 8'h00;
          n.rxOn = 1'b0;
          n.rsp = 128'h0;
          // bits left after the start bit: content plus stop
          n.cnt = (rk == RK_R2) ? LONG_LEN - 8'h01 : CMD_LEN - 8'h01;
          n.st = (rk == RK_NONE) ? H_IDLE : H_RESP;
        end
      end
      H_RESP: if (hRise) begin
        if (!r.rxOn) begin
          if (!r.cmdB) begin
            n.rxOn = 1'b1;
          end else begin
            n.tmo = r.tmo + 8'h01;
            if (r.tmo == RESP_TMO - 8'h01) begin
              n.tmoErr = 1'b1;
              n.st = H_IDLE;
            end
          end
        end else if (r.cnt == 8'h01) begin
          n.stopErr = ~r.cmdB;
          n.dIdx = 8'h00;
          n.tmo = 8'h00;
          n.st = (r.cmdB && dir != 2'h0) ? H_DATA : H_IDLE;
        end else begin
          n.rsp = {r.rsp[126:0], r.cmdB};
          n.cnt = r.cnt - 8'h01;
        end
      end
      H_DATA: if (dir == DIR_RD) begin
        if (hRise) begin
          if (r.dIdx == 8'h00) begin
            if (!r.datB[0]) begin
              n.dIdx = 8'h01;
            end else begin
              n.tmo = r.tmo + 8'h01;
              if (r.tmo == RESP_TMO - 8'h01) begin
                n.tmoErr = 1'b1;
                n.st = H_IDLE;
              end
            end
          end else if (r.dIdx <= units) begin
            n.dSr = r.wide ? {r.dSr[27:0], r.datB} : {r.dSr[30:0], r.datB[0]};
            n.dIdx = r.dIdx + 8'h01;
          end else begin
            n.stopErr = ~r.datB[0];
            n.rxWord = r.dSr;
            n.st = H_IDLE;
          end
        end
      end else if (hFall) begin
        n.dIdx = r.dIdx + 8'h01;
        n.datOe = r.wide ? 4'hf : 4'h1;
        if (r.dIdx == 8'h00) begin
          n.datO = 4'h0;
          n.dSr = r.txWord;
        end else if (r.dIdx <= units) begin
          n.datO = r.wide ? r.dSr[31:28] : {3'b111, r.dSr[31]};
          n.dSr = r.wide ? {r.dSr[27:0], 4'h0} : {r.dSr[30:0], 1'b0};
        end else if (r.dIdx == units + 8'h01) begin
          n.datO = 4'hf;
        end else begin
          n.datO = 4'h0;
          n.datOe = {r.spiSel, 3'b000};
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  // one register stage for all state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r <= '0;
      r.st <= H_INIT;
      r.cmdO <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.sdClk = r.sdClk;
  assign bus.hCmdO = r.cmdO;
  assign bus.hCmdOe = r.cmdOe;
  assign bus.hDatO = r.datO;
  assign bus.hDatOe = r.datOe;
  assign wbDatR = r.rdat;
  assign wbAck = r.ack;
  assign hostState = r.st;
endmodule

// ---- testbench/sdbi_assertions.sv ----
// checker of the sd bus link: framing, drive rules and link clock shape
`timescale 1ns/1ps
module sdbi_assertions (
  input wire logic ref_clk, // system clock
  input wire logic srst, // sync reset
  input wire logic sdClk, // link clock
  input wire logic hCmdO, // host cmd value
  input wire logic hCmdOe, // host cmd enable
  input wire logic dCmdO, // card cmd value
  input wire logic dCmdOe, // card cmd enable
  input wire logic [3:0] hDatO, // host data values
  input wire logic [3:0] hDatOe, // host data enables
  input wire logic [3:0] dDatO, // card data values
  input wire logic [3:0] dDatOe, // card data enables
  input wire logic dPullEn // card data3 pull-up
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [10:0] idleCnt_r;
  // cycles since reset; saturates so a long run never wraps under the limit
  always_ff @(posedge ref_clk) begin
    if (srst) idleCnt_r <= 11'h000;
    else if (idleCnt_r != 11'h7ff) idleCnt_r <= idleCnt_r + 11'h001;
  end
  property p_hStart; $rose(hCmdOe) |-> !hCmdO; endproperty
  a_hStart: assert property (p_hStart) else $error("host frame lacks start bit");
  property p_hStop; $fell(hCmdOe) |-> $past(hCmdO); endproperty
  a_hStop: assert property (p_hStop) else $error("host frame lacks stop bit");
  property p_dStart; $rose(dCmdOe) |-> !dCmdO; endproperty
  a_dStart: assert property (p_dStart) else $error("answer lacks start bit");
  property p_dStop; $fell(dCmdOe) |-> $past(dCmdO); endproperty
  a_dStop: assert property (p_dStop) else $error("answer lacks stop bit");
  property p_oneDrv; !(hCmdOe && dCmdOe); endproperty
  a_oneDrv: assert property (p_oneDrv) else $error("both ends drive command");
  property p_width; dDatOe == 4'h0 || dDatOe == 4'h1 || dDatOe == 4'hf; endproperty
  a_width: assert property (p_width) else $error("card data width not 1 or 4");
  property p_datStart; $rose(dDatOe[0]) |-> !dDatO[0] && !$rose(hDatOe[0]); endproperty
  a_datStart: assert property (p_datStart) else $error("card block start wrong");
  property p_hDatStart; $rose(hDatOe[0]) |-> !hDatO[0]; endproperty
  a_hDatStart: assert property (p_hDatStart) else $error("host block start wrong");
  property p_pull; $fell(srst) |-> dPullEn; endproperty
  a_pull: assert property (p_pull) else $error("pull-up off after reset");
  property p_dummy; hCmdOe |-> idleCnt_r >= 11'h4a0; endproperty
  a_dummy: assert property (p_dummy) else $error("command before idle clocks");
  property p_clk; $rose(sdClk) |=> sdClk [*7] ##1 !sdClk; endproperty
  a_clk: assert property (p_clk) else $error("link clock half period wrong");
  cover property ($rose(dCmdOe));
  cover property ($rose(dDatOe[0]));
  cover property ($rose(hDatOe[0]));
  cover property (dDatOe == 4'hf);
endmodule

// ---- testbench/sd_card_bus_init_tb_top.sv ----
// bench for the sd bus link: host and card joined, host driven over wishbone
`timescale 1ns/1ps
module sd_card_bus_init_tb_top;
  import sdbi_pkg::*;
  typedef struct packed {
    logic [5:0] ix;
    logic [1:0] rk;
    logic [1:0] dir;
    logic [1:0] asel;
    logic [4:0] st;
  } sdbi_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, spiMode, wideBus;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0000_0000, wbDatR, q, st, arg, storedWord;
  logic [15:0] relAddr, relative_card_address;
  logic [127:0] resp;
  sdbi_host_st_t hostState;
  sdbi_card_st_t cardState;
  int fail_count = 0, n_compared = 0;
  sdbi_row_t rows [21];
  sdbi_if u_sdbi_if ();
  // 100 mhz system clock
  always #5 ref_clk = ~ref_clk;
  sdbi_host u_sdbi_host (.ref_clk(ref_clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .hostState(hostState), .bus(u_sdbi_if.host));
  sdbi_card u_sdbi_card (.ref_clk(ref_clk), .srst(srst), .bus(u_sdbi_if.dev),
    .cardState(cardState), .spiMode(spiMode), .wideBus(wideBus), .relAddr(relAddr),
    .storedWord(storedWord));
  sdbi_assertions u_sdbi_assertions (.ref_clk(ref_clk), .srst(srst), .sdClk(u_sdbi_if.sdClk),
    .hCmdO(u_sdbi_if.hCmdO), .hCmdOe(u_sdbi_if.hCmdOe), .dCmdO(u_sdbi_if.dCmdO),
    .dCmdOe(u_sdbi_if.dCmdOe), .hDatO(u_sdbi_if.hDatO), .hDatOe(u_sdbi_if.hDatOe),
    .dDatO(u_sdbi_if.dDatO), .dDatOe(u_sdbi_if.dDatOe), .dPullEn(u_sdbi_if.dPullEn));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a spent wait bound counts as a mismatch and ends the run
  task automatic guard(input logic bad);
    if (bad) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic chkW(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkS(input logic [4:0] g, input logic [4:0] e);
    chkW(128'(g), 128'(e));
  endtask
  // classic cycle: hold everything until ack is sampled, take data there
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    guard(n >= 20);
  endtask
  // start a command, poll busy, then fetch the received answer bits
  task automatic cmd(input logic [31:0] a, input logic [9:0] w);
    int n;
    n = 0;
    wb(1'b1, A_ARG, a);
    wb(1'b1, A_CMD, {22'h000000, w});
    do begin
      wb(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    st = q;
    guard(n >= 3000);
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, A_RESP0 + 8'(4 * k), 32'h0000_0000);
      resp[32 * k +: 32] = q;
    end
  endtask
  // reset both ends, check the power-up values, wait for the idle clocks
  task automatic rst();
    int n;
    n = 0;
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chkS(hostState, H_INIT);
    chkW(128'({wideBus, u_sdbi_if.dPullEn}), 128'h1);
    do begin
      wb(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end while (q[3] !== 1'b1 && n < 1000);
    guard(n >= 1000);
    chkS(hostState, H_IDLE);
    $display("reset test done");
  endtask
  // init sequence rows: index, answer kind, data direction, argument source, state after
  initial begin
    rows = '{'{IX_GO_IDLE, RK_NONE, 2'h0, 2'h0, C_IDLE}, '{IX_APP, RK_R1, 2'h0, 2'h0, C_IDLE},
      '{IX_OP_COND, RK_R3, 2'h0, 2'h0, C_IDLE}, '{IX_APP, RK_R1, 2'h0, 2'h0, C_IDLE},
      '{IX_OP_COND, RK_R3, 2'h0, 2'h2, C_IDLE}, '{IX_APP, RK_R1, 2'h0, 2'h0, C_IDLE},
      '{IX_OP_COND, RK_R3, 2'h0, 2'h2, C_READY}, '{IX_ALL_ID, RK_R2, 2'h0, 2'h0, C_IDENT},
      '{IX_REL_ADDR, RK_R1, 2'h0, 2'h0, C_STBY}, '{IX_SELECT, RK_R1, 2'h0, 2'h1, C_TRAN},
      '{IX_APP, RK_R1, 2'h0, 2'h1, C_TRAN}, '{IX_PULLUP, RK_R1, 2'h0, 2'h0, C_TRAN},
      '{IX_APP, RK_R1, 2'h0, 2'h1, C_TRAN}, '{IX_STATUS, RK_R1, DIR_RD, 2'h0, C_TRAN},
      '{IX_SELECT, RK_NONE, 2'h0, 2'h0, C_STBY}, '{IX_SEND_SPEC, RK_R2, 2'h0, 2'h1, C_STBY},
      '{IX_SEND_ID, RK_R2, 2'h0, 2'h1, C_STBY}, '{IX_SELECT, RK_R1, 2'h0, 2'h1, C_TRAN},
      '{IX_APP, RK_R1, 2'h0, 2'h1, C_TRAN}, '{IX_BUS_W, RK_R1, 2'h0, 2'h3, C_TRAN},
      '{IX_WRITE, RK_R1, DIR_WR, 2'h1, C_TRAN}};
    relative_card_address = 16'h0000;
    rst();
    for (int i = 0; i < 21; i++) begin
      arg = rows[i].asel == 2'h1 ? {relative_card_address, 16'h0000} : rows[i].asel == 2'h2 ? OCR_VOLT :
        {30'h0, rows[i].asel == 2'h3 ? BUSW_4 : 2'h0};
      wb(1'b1, A_DATA, 32'hc3a5_5a3c);
      cmd(arg, {rows[i].dir, rows[i].rk, rows[i].ix});
      if (rows[i].rk != RK_NONE) chkW(128'(st[1]), 128'h0);
      chkS(cardState, rows[i].st);
      case (i)
        2: chkW(128'(resp[38:7]), 128'(OCR_VOLT));
        4: chkW(128'(resp[38]), 128'h0);
        6: chkW(128'(resp[38]), 128'h1);
        7, 16: chkW(resp, {1'b1, ID_VAL[127:1]});
        8: begin
          relative_card_address = resp[38:23];
          chkW(128'(relative_card_address != 16'h0000 && relAddr === relative_card_address), 128'h1);
        end
        11: chkW(128'(u_sdbi_if.dPullEn), 128'h0);
        13: begin
          wb(1'b0, A_DATA, 32'h0000_0000);
          chkW(128'(q), 128'(STAT_WORD));
        end
        15: chkW(resp, {1'b1, SPEC_VAL[127:1]});
        19: begin
          chkW(128'(wideBus), 128'h1);
          wb(1'b1, A_CTRL, 32'h0000_0001);
        end
        20: chkW(128'(storedWord), 128'hc3a5_5a3c);
        default: ;
      endcase
      $display("row %0d done", i);
    end
    // stored block read back over four lines
    cmd(32'h0000_0000, {DIR_RD, RK_R1, IX_READ});
    wb(1'b0, A_DATA, 32'h0000_0000);
    chkW(128'(q), 128'hc3a5_5a3c);
    // identity request while selected gets no answer: host must flag a timeout
    cmd(32'h0000_0000, {2'h0, RK_R2, IX_ALL_ID});
    chkW(128'(st[1]), 128'h1);
    rst();
    // spi select holds until the next reset command; other commands go unanswered
    wb(1'b1, A_CTRL, 32'h0000_0002);
    cmd(32'h0000_0000, {2'h0, RK_NONE, IX_GO_IDLE});
    chkW(128'(spiMode), 128'h1);
    cmd(32'h0000_0000, {2'h0, RK_R1, IX_APP});
    chkW(128'({spiMode, st[1]}), 128'h3);
    wb(1'b1, A_CTRL, 32'h0000_0000);
    cmd(32'h0000_0000, {2'h0, RK_NONE, IX_GO_IDLE});
    chkW(128'(spiMode), 128'h0);
    // unmapped space reads as zero
    wb(1'b0, 8'h40, 32'h0000_0000);
    chkW(128'(q), 128'h0);
    $display("hand tests done");
    tally_and_finish();
  end
endmodule
